// *** common/mqs_pkg.sv ***
// measurement query sequencer: shared types, constants and decode functions
package mqs_pkg;

   // =====================================================================
   // commands, functions and sequencer states
   typedef enum logic [2:0] {
      OP_FETCH, OP_READ, OP_MEAS, OP_INIT, OP_ABORT, OP_CONF
   } mqs_op_t;

   typedef enum logic [3:0] {
      FN_FREQ, FN_PER, FN_RATIO, FN_VMAX, FN_VMIN, FN_PTP, FN_TINT, FN_PHASE,
      FN_DCYC, FN_PWID, FN_NWID, FN_RISE, FN_FALL, FN_TOT_TIMED, FN_TOT_CONT
   } mqs_func_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ABORT, ST_START, ST_WAIT, ST_EVAL
   } mqs_state_t;

   // =====================================================================
   // widths, reset values and response constants
   localparam int        MANT_W      = 50;
   localparam int        EXP_W       = 9;
   localparam int        ERR_W       = 16;
   localparam mqs_func_t FUNC_RST    = FN_FREQ;
   localparam logic [1:0] CH_DFLT_A  = 2'h1;
   localparam logic [1:0] CH_DFLT_B  = 2'h2;
   localparam logic [1:0] CH_NONE    = 2'h0;
   // not-a-number as mantissa and decimal exponent: 991E35
   localparam logic [MANT_W-1:0] NAN_MANT = 50'h0_0000_0000_03DF;
   localparam logic [EXP_W-1:0]  NAN_EXP  = 9'h023;
   localparam logic [3:0] NAN_DIGITS = 4'h3;
   localparam logic [3:0] DIG_MIN    = 4'h1;
   localparam logic [3:0] DIG_MAX    = 4'hF;
   localparam logic [ERR_W-1:0] ERR_STALE    = 16'hFF1A;   // -230
   localparam logic [ERR_W-1:0] ERR_SETTINGS = 16'hFF23;   // -221
   localparam logic [ERR_W-1:0] ERR_PARAM    = 16'hFF20;   // -224
   localparam logic [ERR_W-1:0] ERR_NONE     = 16'h0000;

   // =====================================================================
   // decode functions
   function automatic logic mqs_is_peak(mqs_func_t f);
      return (f == FN_VMAX) || (f == FN_VMIN) || (f == FN_PTP);
   endfunction

   function automatic logic mqs_two_chan(mqs_func_t f);
      return (f == FN_RATIO) || (f == FN_TINT) || (f == FN_PHASE);
   endfunction

   function automatic logic mqs_derivable(mqs_func_t have, mqs_func_t want);
      logic fp;
      fp = ((have == FN_FREQ) || (have == FN_PER)) &&
           ((want == FN_FREQ) || (want == FN_PER));
      return (have == want) || fp || (mqs_is_peak(have) && mqs_is_peak(want));
   endfunction

endpackage

// *** src/mqs_chan.sv ***
// measurement query sequencer: channel list check and default channels
`timescale 1ns/10ps
`default_nettype none
module mqs_chan
   import mqs_pkg::*;
(
   // request
   input  wire mqs_pkg::mqs_func_t func,
   input  wire logic               chan_given,
   input  wire logic [1:0]         chan_cnt,
   input  wire logic [1:0]         ch_a,
   input  wire logic [1:0]         ch_b,
   // result
   output logic [1:0]              eff_a,
   output logic [1:0]              eff_b,
   output logic                    ok
);
   logic two;

   always_comb begin
      two = mqs_two_chan(func);
      if (!chan_given) begin
         // omitted list takes the function's default channels
         eff_a = CH_DFLT_A;
         eff_b = two ? CH_DFLT_B : CH_NONE;
         ok    = 1'b1;
      end else if (two) begin
         eff_a = ch_a;
         eff_b = ch_b;
         ok    = (chan_cnt == 2'h2) && (ch_a != CH_NONE) && (ch_b != CH_NONE) && (ch_a != ch_b);
      end else begin
         eff_a = ch_a;
         eff_b = CH_NONE;
         ok    = (chan_cnt == 2'h1) && (ch_a != CH_NONE);
      end
   end
endmodule // mqs_chan
`default_nettype wire

// *** src/mqs_fmt.sv ***
// measurement query sequencer: result formatter (not-a-number and digit count)
`timescale 1ns/10ps
`default_nettype none
module mqs_fmt
   import mqs_pkg::*;
(
   // raw result
   input  wire logic                nan,
   input  wire logic [MANT_W-1:0]   mant,
   input  wire logic [EXP_W-1:0]    expo,
   input  wire logic [3:0]          digits,
   // formatted result
   output logic [MANT_W-1:0]        o_mant,
   output logic [EXP_W-1:0]         o_exp,
   output logic [3:0]               o_digits
);
   always_comb begin
      if (nan) begin
         o_mant   = NAN_MANT;
         o_exp    = NAN_EXP;
         o_digits = NAN_DIGITS;
      end else begin
         o_mant   = mant;
         o_exp    = expo;
         // a zero digit count from the front end still shows one digit
         o_digits = (digits < DIG_MIN) ? DIG_MIN : digits;
      end
   end
endmodule // mqs_fmt
`default_nettype wire

// *** src/mqs_seq.sv ***
// measurement query sequencer: fetch, read and measure query execution
//
// Overview of operation
// - fetch returns result only if same or derivable
// - non-derivable request forces new acquisition
// - omitted function reuses last used function
// - fetch during measurement holds off later commands
// - no valid result: not-a-number, error -230
// - fetch during auto totalize: error -221
// - result format follows ascii or real setting
// - ascii result carries 1 to 15 digits
// - measure aborts running measurement, waits, holds off
// - omitted parameters and channels take defaults
// - measure switches off math, statistics, limits
// - measure enables auto trigger on channels
// - read always acquires fresh data then fetches
// - read aborts, idles cycle, restarts, holds off
// - read with auto totalize: error -221
// - continuous totalize refused by measure, read
// - channel lists: one channel or ordered pair
// - initiate acquires; fetch serves stored data
`timescale 1ns/10ps
`default_nettype none
module mqs_seq
   import mqs_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   dev_clear,
   // command from parser
   input  wire logic                   cmd_valid,
   output logic                        cmd_ready,
   input  wire mqs_pkg::mqs_op_t       cmd_op,
   input  wire mqs_pkg::mqs_func_t     cmd_func,
   input  wire logic                   cmd_func_given,
   input  wire logic [3:0]             cmd_par_dflt,
   input  wire logic                   cmd_chan_given,
   input  wire logic [1:0]             cmd_chan_cnt,
   input  wire logic [1:0]             cmd_ch_a,
   input  wire logic [1:0]             cmd_ch_b,
   input  wire logic                   fmt_real,
   // measurement front end
   output logic                        fe_start,
   output logic                        fe_abort,
   output mqs_pkg::mqs_func_t          fe_func,
   output mqs_pkg::mqs_func_t          fe_sel_func,
   output logic [1:0]                  fe_ch_a,
   output logic [1:0]                  fe_ch_b,
   output logic [3:0]                  fe_par_dflt,
   output logic                        fe_math_off,
   output logic                        fe_trig_auto,
   input  wire logic                   fe_busy,
   input  wire logic                   fe_done,
   input  wire logic                   fe_ok,
   input  wire logic                   fe_tot_auto,
   input  wire logic [MANT_W-1:0]      fe_mant,
   input  wire logic [EXP_W-1:0]       fe_exp,
   input  wire logic [3:0]             fe_digits,
   // response to output queue
   output logic                        resp_valid,
   output logic                        resp_real,
   output logic                        resp_nan,
   output logic [MANT_W-1:0]           resp_mant,
   output logic [EXP_W-1:0]            resp_exp,
   output logic [3:0]                  resp_digits,
   output logic                        err_valid,
   output logic [ERR_W-1:0]            err_code
);

   // ======================================================================
   // state
   typedef struct packed {
      mqs_state_t         st;
      mqs_func_t          cur_func;
      mqs_func_t          meas_func;
      mqs_func_t          want;
      logic               data_ok;
      logic               ready;
      logic               fe_start;
      logic               fe_abort;
      mqs_func_t          fe_func;
      logic [1:0]         ch_a;
      logic [1:0]         ch_b;
      logic [3:0]         par_dflt;
      logic               math_off;
      logic               trig_auto;
      logic               resp_valid;
      logic               resp_real;
      logic               resp_nan;
      logic [MANT_W-1:0]  resp_mant;
      logic [EXP_W-1:0]   resp_exp;
      logic [3:0]         resp_digits;
      logic               err_valid;
      logic [ERR_W-1:0]   err_code;
   } mqs_seq_t;

   mqs_seq_t q, d;

   // ======================================================================
   // helpers
   logic              acc;
   mqs_func_t         req;
   logic              fmt_nan;
   logic [MANT_W-1:0] f_mant;
   logic [EXP_W-1:0]  f_exp;
   logic [3:0]        f_digits;
   logic [1:0]        eff_a;
   logic [1:0]        eff_b;
   logic              chan_ok;
   logic              can_derive;

   assign acc        = cmd_valid && q.ready && (q.st == ST_IDLE) && !dev_clear;
   assign req        = cmd_func_given ? cmd_func : q.cur_func;
   assign can_derive = mqs_derivable(q.meas_func, q.want);
   assign fmt_nan    = !q.data_ok;

   mqs_chan u_chan (
      .func       (req),
      .chan_given (cmd_chan_given),
      .chan_cnt   (cmd_chan_cnt),
      .ch_a       (cmd_ch_a),
      .ch_b       (cmd_ch_b),
      .eff_a      (eff_a),
      .eff_b      (eff_b),
      .ok         (chan_ok)
   );

   mqs_fmt u_fmt (
      .nan      (fmt_nan),
      .mant     (fe_mant),
      .expo     (fe_exp),
      .digits   (fe_digits),
      .o_mant   (f_mant),
      .o_exp    (f_exp),
      .o_digits (f_digits)
   );

   // ======================================================================
   // next state
   always_comb begin
      d            = q;
      d.fe_start   = 1'b0;
      d.fe_abort   = 1'b0;
      d.math_off   = 1'b0;
      d.trig_auto  = 1'b0;
      d.resp_valid = 1'b0;
      d.err_valid  = 1'b0;
      // a completion with fe_ok leaves a stored data set for later fetches; one without fe_ok clears data_ok
      if (fe_done) begin
         d.data_ok = fe_ok;
      end
      case (q.st)
         ST_IDLE: begin
            if (acc) begin
               case (cmd_op)
                  OP_CONF: begin
                     d.cur_func = cmd_func;
                     d.ch_a     = eff_a;
                     d.ch_b     = eff_b;
                     d.par_dflt = cmd_par_dflt;
                  end
                  OP_INIT: begin
                     d.fe_start  = 1'b1;
                     d.fe_func   = q.cur_func;
                     d.meas_func = q.cur_func;
                     d.data_ok   = 1'b0;
                  end
                  OP_ABORT: begin
                     d.fe_abort = 1'b1;
                  end
                  OP_FETCH: begin
                     d.want     = req;
                     d.cur_func = req;
                     if (fe_busy && fe_tot_auto) begin
                        d.resp_valid = 1'b1;
                        d.err_valid  = 1'b1;
                        d.err_code   = ERR_SETTINGS;
                     end else if (fe_busy) begin
                        d.st = ST_WAIT;
                     end else begin
                        d.st = ST_EVAL;
                     end
                  end
                  default: begin
                     // read and measure
                     if (cmd_op == OP_READ && fe_tot_auto) begin
                        d.resp_valid = 1'b1;
                        d.err_valid  = 1'b1;
                        d.err_code   = ERR_SETTINGS;
                     end else if (req == FN_TOT_CONT ||
                                  (cmd_op == OP_MEAS && !chan_ok)) begin
                        d.resp_valid = 1'b1;
                        d.err_valid  = 1'b1;
                        d.err_code   = ERR_PARAM;
                     end else begin
                        d.want     = req;
                        d.cur_func = req;
                        if (cmd_op == OP_MEAS) begin
                           // channel defaults already substituted by u_chan; parameter defaults left to the front end
                           d.ch_a      = eff_a;
                           d.ch_b      = eff_b;
                           d.par_dflt  = cmd_par_dflt;
                           d.math_off  = 1'b1;
                           d.trig_auto = 1'b1;
                        end
                        if (fe_busy) begin
                           d.fe_abort = 1'b1;
                           d.st       = ST_ABORT;
                        end else begin
                           d.st = ST_START;
                        end
                     end
                  end
               endcase
            end
         end
         ST_ABORT: begin
            // measurement cycle back to idle before restart
            if (!fe_busy) begin
               d.st = ST_START;
            end
         end
         ST_START: begin
            // fresh acquisition of the wanted type
            d.fe_start  = 1'b1;
            d.fe_func   = q.want;
            d.meas_func = q.want;
            d.data_ok   = 1'b0;
            d.st        = ST_WAIT;
         end
         ST_WAIT: begin
            if (fe_done) begin
               d.st = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (!can_derive) begin
               // stored data is of another kind
               d.st = ST_START;
            end else begin
               d.resp_valid = 1'b1;
               // format setting sampled with the result
               d.resp_real  = fmt_real;
               d.resp_nan   = !q.data_ok;
               d.resp_mant  = f_mant;
               d.resp_exp   = f_exp;
               d.resp_digits = f_digits;
               d.err_valid  = !q.data_ok;
               d.err_code   = q.data_ok ? ERR_NONE : ERR_STALE;
               d.st         = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      if (d.err_valid && d.resp_valid && (q.st == ST_IDLE)) begin
         d.resp_real   = fmt_real;
         d.resp_nan    = 1'b1;
         d.resp_mant   = NAN_MANT;
         d.resp_exp    = NAN_EXP;
         d.resp_digits = NAN_DIGITS;
      end
      if (dev_clear) begin
         d.st       = ST_IDLE;
         d.fe_start = 1'b0;
         d.fe_abort = fe_busy;
      end
      // commands taken only while idle
      // a quiet cycle after a start or abort lets busy settle first
      d.ready = (d.st == ST_IDLE) && !d.resp_valid && !d.fe_start && !d.fe_abort;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q          <= '0;
         q.st       <= ST_IDLE;
         q.cur_func <= FUNC_RST;
         q.meas_func <= FUNC_RST;
         q.want     <= FUNC_RST;
         q.fe_func  <= FUNC_RST;
      end else begin
         q <= d;
      end
   end

   // ======================================================================
   // outputs
   assign cmd_ready    = q.ready;
   assign fe_start     = q.fe_start;
   assign fe_abort     = q.fe_abort;
   assign fe_func      = q.fe_func;
   assign fe_sel_func  = q.want;
   assign fe_ch_a      = q.ch_a;
   assign fe_ch_b      = q.ch_b;
   assign fe_par_dflt  = q.par_dflt;
   assign fe_math_off  = q.math_off;
   assign fe_trig_auto = q.trig_auto;
   assign resp_valid   = q.resp_valid;
   assign resp_real    = q.resp_real;
   assign resp_nan     = q.resp_nan;
   assign resp_mant    = q.resp_mant;
   assign resp_exp     = q.resp_exp;
   assign resp_digits  = q.resp_digits;
   assign err_valid    = q.err_valid;
   assign err_code     = q.err_code;

   // ======================================================================
   // assertions
   AST_HOLD_OFF: assert property (@(posedge clk) disable iff (!rstn)
      (q.st == ST_WAIT && !fe_done && !dev_clear) |=> (q.st == ST_WAIT && !cmd_ready))
      else $error("command taken while waiting for a measurement");

   AST_STALE: assert property (@(posedge clk) disable iff (!rstn)
      (q.st == ST_EVAL && can_derive && !q.data_ok && !dev_clear) |=>
      (resp_valid && resp_nan && err_valid && err_code == ERR_STALE))
      else $error("missing result did not give not-a-number and -230");

   AST_TOT_FETCH: assert property (@(posedge clk) disable iff (!rstn)
      (acc && cmd_op == OP_FETCH && fe_busy && fe_tot_auto) |=>
      (resp_nan && resp_mant == NAN_MANT && err_code == ERR_SETTINGS))
      else $error("fetch during totalize did not give -221");

   AST_TOT_READ: assert property (@(posedge clk) disable iff (!rstn)
      (acc && cmd_op == OP_READ && fe_tot_auto) |=>
      (err_valid && err_code == ERR_SETTINGS && !fe_start))
      else $error("read with auto totalize did not give -221");

   AST_MEAS_SETUP: assert property (@(posedge clk) disable iff (!rstn)
      (acc && cmd_op == OP_MEAS && req != FN_TOT_CONT && chan_ok) |=>
      (fe_math_off && fe_trig_auto && !cmd_ready))
      else $error("measure did not switch off math or set auto trigger");

   AST_ABORT_FIRST: assert property (@(posedge clk) disable iff (!rstn)
      (acc && cmd_op == OP_READ && !fe_tot_auto && req != FN_TOT_CONT && fe_busy) |=>
      (fe_abort && !fe_start) ##1 !fe_start)
      else $error("read restarted without aborting first");

   AST_CONT_REFUSED: assert property (@(posedge clk) disable iff (!rstn)
      (acc && (cmd_op == OP_MEAS || cmd_op == OP_READ) && req == FN_TOT_CONT) |=>
      (err_valid && !fe_start) ##1 !fe_start)
      else $error("continuous totalize accepted by measure or read");

   AST_NEW_ACQ: assert property (@(posedge clk) disable iff (!rstn)
      (q.st == ST_EVAL && !can_derive && !dev_clear) |=>
      (!resp_valid ##1 ($past(dev_clear) || (fe_start && fe_func == $past(q.want, 2)))))
      else $error("foreign function did not start a new acquisition");

   AST_DIGITS: assert property (@(posedge clk) disable iff (!rstn)
      (resp_valid && !resp_nan) |-> (resp_digits >= DIG_MIN && resp_digits <= DIG_MAX))
      else $error("digit count out of range");

   AST_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
      dev_clear |=> (q.st == ST_IDLE && !fe_start))
      else $error("device clear did not release the hold-off");

endmodule // mqs_seq
`default_nettype wire

// *** dv/mqs_fe_model.sv ***
// front end model: acquisition timer with abort and result status
`timescale 1ns/10ps
`default_nettype none
module mqs_fe_model (
   // control from sequencer
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       fe_start,
   input  wire logic       fe_abort,
   // bench settings
   input  wire logic [7:0] lat,
   input  wire logic       ok_in,
   // status to sequencer
   output logic            fe_busy,
   output logic            fe_done,
   output logic            fe_ok
);
   logic [7:0] cnt_q;
   // ==========================================================
   // acquisition timer
   // acquire then done
   always @(posedge clk) begin
      fe_done <= 1'b0;
      if (!rstn) begin
         fe_busy <= 1'b0;
         fe_ok   <= 1'b0;
         cnt_q   <= 8'h00;
      end else if (fe_abort) begin
         fe_busy <= 1'b0;
      end else if (fe_start) begin
         fe_busy <= 1'b1;
         cnt_q   <= lat;
      end else if (fe_busy && cnt_q <= 8'h01) begin
         // done never in the start cycle
         fe_busy <= 1'b0;
         fe_done <= 1'b1;
         fe_ok   <= ok_in;
      end else if (fe_busy) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
endmodule // mqs_fe_model
`default_nettype wire

// *** dv/measurement_query_sequencer_test.sv ***
// testbench: query sequencer against a queue model and front end model
`timescale 1ns/10ps
`default_nettype none
module measurement_query_sequencer_test;
   import mqs_pkg::*;
   logic clk, rstn, dev_clear, cmd_valid, cmd_ready, cmd_func_given;
   logic cmd_chan_given, fmt_real, fe_start, fe_abort, fe_math_off;
   logic fe_trig_auto, fe_busy, fe_done, fe_ok, fe_tot_auto, ok_in;
   logic resp_valid, resp_real, resp_nan, err_valid;
   logic [1:0] cmd_chan_cnt, cmd_ch_a, cmd_ch_b, fe_ch_a, fe_ch_b, l_a, l_b;
   logic [3:0] cmd_par_dflt, fe_par_dflt, fe_digits, resp_digits, l_pd;
   logic [7:0] lat;
   logic [MANT_W-1:0] fe_mant, resp_mant;
   logic [EXP_W-1:0] fe_exp, resp_exp;
   logic [ERR_W-1:0] err_code;
   logic [80:0] exp_q[$];
   logic [80:0] e;
   mqs_op_t cmd_op;
   mqs_func_t cmd_func, fe_func, fe_sel_func, l_fn, l_sel;
   int bad_count = 0, comparisons = 0, n_st = 0, n_ab = 0, n_mo = 0, n_ta = 0;

   mqs_seq i_dut (.clk, .rstn, .dev_clear, .cmd_valid, .cmd_ready, .cmd_op, .cmd_func,
      .cmd_func_given, .cmd_par_dflt, .cmd_chan_given, .cmd_chan_cnt, .cmd_ch_a,
      .cmd_ch_b, .fmt_real, .fe_start, .fe_abort, .fe_func, .fe_sel_func, .fe_ch_a,
      .fe_ch_b, .fe_par_dflt, .fe_math_off, .fe_trig_auto, .fe_busy, .fe_done, .fe_ok,
      .fe_tot_auto, .fe_mant, .fe_exp, .fe_digits, .resp_valid, .resp_real, .resp_nan,
      .resp_mant, .resp_exp, .resp_digits, .err_valid, .err_code);
   mqs_fe_model i_fe (.clk, .rstn, .fe_start, .fe_abort, .lat, .ok_in, .fe_busy,
      .fe_done, .fe_ok);

   // ==========================================================
   // checking helpers
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task summarize;
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // expected response: data as presented, or not-a-number with error
   task qx(input logic nan, input logic [15:0] er);
      if (nan)
         exp_q.push_back({1'b1, fmt_real, NAN_MANT, NAN_EXP, NAN_DIGITS, er});
      else
         exp_q.push_back({1'b0, fmt_real, fe_mant, fe_exp, fe_digits, ERR_NONE});
   endtask
   task nd;
      fe_mant = MANT_W'({$urandom(), $urandom()});
      fe_exp = EXP_W'($urandom());
      fe_digits = 4'(1 + $urandom() % 15);
      fmt_real = 1'($urandom());
   endtask
   // one command; valid held until the edge that takes it
   task cmd(input mqs_op_t op, input mqs_func_t f, input logic g,
            input logic [1:0] cn, input logic [1:0] ca, input logic [1:0] cb);
      int i;
      @(negedge clk);
      cmd_op = op;
      cmd_func = f;
      cmd_func_given = g;
      cmd_chan_given = (cn != 2'h0);
      cmd_chan_cnt = cn;
      cmd_ch_a = ca;
      cmd_ch_b = cb;
      cmd_par_dflt = 4'($urandom());
      cmd_valid = 1'b1;
      for (i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(negedge clk);
      chk(cmd_ready === 1'b1, "command not taken");
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask
   task drain;
      int i;
      for (i = 0; i < 300 && exp_q.size() > 0; i++) @(negedge clk);
      chk(exp_q.size() == 0, "response missing");
      repeat (2) @(negedge clk);
   endtask

   // ==========================================================
   // monitors
   always @(negedge clk) begin
      if (rstn && resp_valid === 1'b1) begin
         chk(exp_q.size() > 0, "unexpected response");
         if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            l_sel = fe_sel_func;
            chk({resp_nan, resp_real, resp_mant, resp_exp, resp_digits} === e[80:16],
                "response value");
            chk(err_valid === (e[15:0] != ERR_NONE), "error flag");
            if (e[15:0] != ERR_NONE)
               chk(err_code === e[15:0], "error code");
         end
      end
      if (fe_start === 1'b1) begin
         n_st++;
         l_fn = fe_func;
         l_a = fe_ch_a;
         l_b = fe_ch_b;
         l_pd = fe_par_dflt;
      end
      if (fe_abort === 1'b1) n_ab++;
      if (fe_math_off === 1'b1) n_mo++;
      if (fe_trig_auto === 1'b1) n_ta++;
   end

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      chk(1'b0, "timeout");
      summarize;
   end

   // ==========================================================
   // main sequence
   initial begin
      int s, m, t;
      {rstn, dev_clear, cmd_valid, cmd_func_given, cmd_chan_given, fe_tot_auto} = '0;
      {cmd_chan_cnt, cmd_ch_a, cmd_ch_b, cmd_par_dflt, fmt_real} = '0;
      {fe_mant, fe_exp, fe_digits} = '0;
      cmd_op = OP_FETCH;
      cmd_func = FN_FREQ;
      lat = 8'h04;
      ok_in = 1'b1;
      void'($urandom(32'hCB15));
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      qx(1'b1, ERR_STALE);
      cmd(OP_FETCH, FN_FREQ, 1'b0, 2'h0, 2'h0, 2'h0);
      drain;
      for (int f = 0; f < 14; f++) begin
         nd;
         qx(1'b0, ERR_NONE);
         s = n_st;
         cmd(OP_CONF, mqs_func_t'(f), 1'b1, 2'h0, 2'h0, 2'h0);
         cmd(OP_READ, mqs_func_t'(f), 1'b1, 2'h0, 2'h0, 2'h0);
         drain;
         chk(n_st == s + 1 && l_fn === mqs_func_t'(f) && l_a === 2'h1, "read start");
         if (f == 2 || f == 6 || f == 7)
            chk(l_b === 2'h2, "default pair");
      end
      nd;
      qx(1'b0, ERR_NONE);
      s = n_st;
      cmd(OP_READ, FN_FREQ, 1'b1, 2'h0, 2'h0, 2'h0);
      qx(1'b0, ERR_NONE);
      cmd(OP_FETCH, FN_PER, 1'b1, 2'h0, 2'h0, 2'h0);
      qx(1'b0, ERR_NONE);
      cmd(OP_FETCH, FN_FREQ, 1'b0, 2'h0, 2'h0, 2'h0);
      drain;
      chk(n_st == s + 1 && l_sel === FN_PER, "derivable fetch reacquired");
      nd;
      qx(1'b0, ERR_NONE);
      cmd(OP_FETCH, FN_VMAX, 1'b1, 2'h0, 2'h0, 2'h0);
      drain;
      chk(n_st == s + 2 && l_fn === FN_VMAX, "new type not acquired");
      nd;
      qx(1'b0, ERR_NONE);
      cmd(OP_READ, FN_FREQ, 1'b0, 2'h0, 2'h0, 2'h0);
      drain;
      chk(l_fn === FN_VMAX, "omitted function");
      for (int k = 0; k < 2; k++) begin
         lat = 8'h28;
         cmd(OP_INIT, FN_FREQ, 1'b1, 2'h0, 2'h0, 2'h0);
         repeat (3) @(negedge clk);
         lat = 8'h03;
         nd;
         qx(1'b0, ERR_NONE);
         {s, m, t} = {n_ab, n_mo, n_ta};
         cmd(k ? OP_READ : OP_MEAS, FN_PER, 1'b1, 2'h0, 2'h0, 2'h0);
         drain;
         chk(n_ab == s + 1 && l_fn === FN_PER, "abort then restart");
         if (k == 0)
            chk(n_mo == m + 1 && n_ta == t + 1, "math off, auto trigger");
      end
      lat = 8'h1E;
      cmd(OP_INIT, FN_PER, 1'b1, 2'h0, 2'h0, 2'h0);
      nd;
      qx(1'b0, ERR_NONE);
      cmd(OP_FETCH, FN_PER, 1'b0, 2'h0, 2'h0, 2'h0);
      repeat (10) @(negedge clk);
      chk(cmd_ready === 1'b0 && fe_busy === 1'b1, "hold-off");
      drain;
      lat = 8'h3C;
      cmd(OP_INIT, FN_PER, 1'b1, 2'h0, 2'h0, 2'h0);
      cmd(OP_FETCH, FN_PER, 1'b0, 2'h0, 2'h0, 2'h0);
      repeat (5) @(negedge clk);
      dev_clear = 1'b1;
      @(negedge clk);
      dev_clear = 1'b0;
      repeat (3) @(negedge clk);
      chk(cmd_ready === 1'b1 && fe_busy === 1'b0, "clear releases");
      fe_tot_auto = 1'b1;
      cmd(OP_INIT, FN_TOT_TIMED, 1'b1, 2'h0, 2'h0, 2'h0);
      qx(1'b1, ERR_SETTINGS);
      cmd(OP_FETCH, FN_TOT_TIMED, 1'b0, 2'h0, 2'h0, 2'h0);
      drain;
      cmd(OP_ABORT, FN_FREQ, 1'b0, 2'h0, 2'h0, 2'h0);
      repeat (3) @(negedge clk);
      qx(1'b1, ERR_SETTINGS);
      cmd(OP_READ, FN_TOT_TIMED, 1'b1, 2'h0, 2'h0, 2'h0);
      drain;
      fe_tot_auto = 1'b0;
      lat = 8'h02;
      qx(1'b1, ERR_PARAM);
      cmd(OP_MEAS, FN_TOT_CONT, 1'b1, 2'h0, 2'h0, 2'h0);
      qx(1'b1, ERR_PARAM);
      cmd(OP_READ, FN_TOT_CONT, 1'b1, 2'h0, 2'h0, 2'h0);
      qx(1'b1, ERR_PARAM);
      cmd(OP_MEAS, FN_TINT, 1'b1, 2'h1, 2'h1, 2'h0);
      drain;
      nd;
      qx(1'b0, ERR_NONE);
      cmd(OP_MEAS, FN_RATIO, 1'b1, 2'h2, 2'h2, 2'h1);
      drain;
      chk(l_a === 2'h2 && l_b === 2'h1 && l_pd === cmd_par_dflt, "pair order");
      ok_in = 1'b0;
      qx(1'b1, ERR_STALE);
      cmd(OP_READ, FN_FREQ, 1'b1, 2'h0, 2'h0, 2'h0);
      drain;
      summarize;
   end
endmodule // measurement_query_sequencer_test
`default_nettype wire
